// ### bench/periph_irq_monitor.sv
// assertion checker on the register bus of the irq block
`timescale 1ns/1ps
module periph_irq_monitor
    import pirq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ************
    // bus checks
    // ************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while pending");
    a_rd_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp ==
        RESP_SLVERR |-> s_axi_rdata == 32'h0) else $error("err data");
    a_b_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY
        || s_axi_bresp == RESP_SLVERR) else $error("bad bresp");
endmodule

// ### bench/periph_model.sv
// peripheral event source for the flag inputs
`timescale 1ns/1ps
module periph_model
    import pirq_pkg::*;
(
    input wire logic aclk,
    input wire events_a_t fire,
    output events_a_t events_a = '0
);
    // one-cycle event strobes
    always @(posedge aclk) begin
        events_a <= fire;
    end
endmodule

// ### bench/testbench.sv
// self-checking bench for the peripheral irq block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
    import pirq_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, serial_rx_full = 1'b0, serial_tx_empty = 1'b0;
    logic clk_en = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, periph_irq;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] periph_irq_request_b = 8'h0;
    events_a_t fire = '0, events_a;
    logic [33:0] exp_q[$], er, gr;
    logic [1:0] exp_b[$], eb;
    int failures = 0, checked = 0, seed = 32'hd33a;
    int map [7] = '{0, 1, 2, 3, 3, 3, 6};
    // ************
    // harness
    // ************
    always #2 aclk = ~aclk;
    periph_irq_flags periph_irq_flags_i(
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .events_a(events_a),
        .serial_rx_full(serial_rx_full),
        .serial_tx_empty(serial_tx_empty),
        .periph_irq_request_b(periph_irq_request_b),
        .periph_irq(periph_irq)
    );
    periph_model periph_model_i(
        .aclk(aclk),
        .fire(fire),
        .events_a(events_a)
    );
    // compare each bus answer with the oldest noted expectation
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            er = exp_q.pop_front();
            gr = {s_axi_rresp, s_axi_rdata};
            `CHK(gr, er)
        end
        if (s_axi_bvalid && s_axi_bready) begin
            eb = exp_b.pop_front();
            `CHK(s_axi_bresp, eb)
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, tb, da = 1'b0, dw = 1'b0;
        int n;
        exp_b.push_back(a[1:0] == 2'b00 ? RESP_OKAY : RESP_SLVERR);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            #1 ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            da |= ta;
            dw |= tw;
        end while (!(da && dw));
        n = $unsigned($random(seed)) % 3;
        repeat (n) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do begin #1 tb = s_axi_bvalid; @(posedge aclk); end while (!tb);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic t;
        int n;
        exp_q.push_back({(a[1:0] == 2'b00 ? RESP_OKAY : RESP_SLVERR), e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin #1 t = s_axi_arready; @(posedge aclk); end while (!t);
        s_axi_arvalid <= 1'b0;
        n = $unsigned($random(seed)) % 3;
        repeat (n) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do begin #1 t = s_axi_rvalid; @(posedge aclk); end while (!t);
        s_axi_rready <= 1'b0;
    endtask
    task automatic irq(input logic e);
        @(posedge aclk);
        #1 `CHK(periph_irq, e)
        @(posedge aclk);
    endtask
    task automatic ev(input events_a_t f);
        fire <= f;
        @(posedge aclk);
        fire <= '0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic end_sim;
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ************
    // scenarios
    // ************
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 16; i += 4) rd(4'(i), 32'h0);
        d = $random(seed);
        wr(4'h0, d);
        rd(4'h0, d & 32'h7f);
        s_axi_wstrb <= 4'he;
        wr(4'h0, 32'h0);
        s_axi_wstrb <= 4'h1;
        rd(4'h0, d & 32'h7f);
        wr(4'h2, 32'hff);
        rd(4'h2, 32'h0);
        wr(4'h4, d);
        rd(4'h4, d & 32'hfd);
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h0);
        for (int i = 0; i < 7; i++) begin
            ev(events_a_t'(7'h1 << i));
            rd(4'h8, 32'h1 << map[i]);
            wr(4'h8, 32'h0);
        end
        clk_en <= 1'b0;
        ev(events_a_t'(7'h40));
        clk_en <= 1'b1;
        rd(4'h8, 32'h0);
        serial_rx_full <= 1'b1;
        serial_tx_empty <= 1'b1;
        wr(4'h8, 32'h0);
        rd(4'h8, 32'h30);
        for (int j = 0; j < 7; j++) begin
            serial_rx_full <= (j == 5);
            serial_tx_empty <= (j == 4);
            wr(4'h8, 32'h1 << j);
            wr(4'h0, 32'h1 << j);
            irq(1'b0);
            wr(4'hc, 32'h1);
            irq(1'b1);
            wr(4'h0, ~(32'h1 << j));
            irq(1'b0);
            wr(4'hc, 32'h0);
        end
        serial_rx_full <= 1'b0;
        serial_tx_empty <= 1'b0;
        wr(4'h8, 32'h0);
        rd(4'h8, 32'h0);
        wr(4'hc, 32'h1);
        for (int j = 0; j < 8; j++) begin
            periph_irq_request_b <= 8'h1 << j;
            wr(4'h4, 32'h1 << j);
            irq(j != 1);
            wr(4'h4, 32'h0);
        end
        wr(4'h4, 32'hff);
        wr(4'hc, 32'h0);
        irq(1'b0);
        end_sim;
    end
endmodule
bind periph_irq_flags periph_irq_monitor periph_irq_monitor_i(
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

// ### rtl/periph_irq_flags.sv
// peripheral interrupt enable and request registers behind axi4-lite
//
// Contract
// - enable_a bit 7 and enable_b bit 1 ignore writes, read zero
// - enable_a bit 6 gates the adc completion request
// - enable_a bit 5 gates the serial receive request
// - enable_a bit 4 gates the serial transmit request
// - enable_a bit 3 gates the synchronous serial port request
// - enable_a bit 2 gates the first capture/compare request
// - enable_a bit 1 gates the timer period match request
// - enable_a bit 0 gates the wide timer overflow request
// - nothing reaches the core without the peripheral group enable
// - enable_b bit 7 gates the oscillator failure request
// - enable_b bits 6 and 5 gate comparator b and a requests
// - enable_b bit 3 gates the bus collision request
// - enable_b bit 2 gates the low power wake request
// - enable_b bit 0 gates the second capture/compare request
// - flags set on events regardless of any enable; events arriving while clk_en is low are lost
// - adc flag set on completion, held until software writes zero
// - rx flag read-only, high while receive buffer holds data
// - tx flag read-only, high while transmit buffer is empty
// - sync port flag set on transfer done, software clears
// - two-wire master sequence ends and idle start also set it
// - capcmp flag set on capture or compare, software clears
// - period match flag set on match, software clears
// - overflow flag set on wide timer overflow, software clears
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module periph_irq_flags
    import pirq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire events_a_t events_a,
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic [7:0] periph_irq_request_b,
    output logic periph_irq
);

    // ****************************************
    // state
    // ****************************************
    state_t state_reg;
    state_t state_next;
    logic [7:0] periph_irq_request_a;
    logic [7:0] set_a;
    logic [7:0] pend_b;
    logic wr_go;
    logic [7:0] wbyte;

    // ****************************************
    // flag view
    // ****************************************
    always_comb begin
        set_a = REG8_RESET;
        set_a[ADC_BIT] = events_a.adc_done;
        set_a[SYNC_BIT] = events_a.sync_done
            | events_a.sync_i2c_seq_done
            | events_a.sync_idle_start;
        set_a[CAPCMP_A_BIT] = events_a.capcmp_a_event;
        set_a[PERIOD_BIT] = events_a.period_match;
        set_a[OVF_BIT] = events_a.wide_timer_ovf;
        periph_irq_request_a = state_reg.request_a_sw;
        periph_irq_request_a[RX_BIT] = serial_rx_full;
        periph_irq_request_a[TX_BIT] = serial_tx_empty;
        pend_b = periph_irq_request_b & ENABLE_B_MASK;
    end

    assign wr_go = state_reg.aw_seen && state_reg.w_seen
        && state_reg.wr_state == BUS_IDLE;
    assign wbyte = state_reg.w_data[7:0];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_seen = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_seen = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            state_next.aw_seen = 1'b0;
            state_next.w_seen = 1'b0;
            state_next.wr_state = BUS_RESP;
            state_next.bresp = RESP_OKAY;
            case (state_reg.aw_addr)
                ENABLE_A_OFFSET: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.periph_irq_enable_a =
                            wbyte & ENABLE_A_MASK;
                    end
                end
                ENABLE_B_OFFSET: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.periph_irq_enable_b =
                            wbyte & ENABLE_B_MASK;
                    end
                end
                REQUEST_A_OFFSET: begin
                    if (state_reg.w_strb[0]) begin
                        // rx and tx positions are not stored
                        state_next.request_a_sw =
                            wbyte & REQUEST_A_SW_MASK;
                    end
                end
                CONTROL_OFFSET: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.peripheral_group_enable =
                            wbyte[GROUP_BIT];
                    end
                end
                default: begin
                    state_next.bresp = RESP_SLVERR;
                end
            endcase
        end
        // event set wins over a software clear in the same cycle
        state_next.request_a_sw = state_next.request_a_sw | set_a;
        if (state_reg.wr_state == BUS_RESP && s_axi_bready) begin
            state_next.wr_state = BUS_IDLE;
        end
        if (state_reg.rd_state == BUS_IDLE && s_axi_arvalid) begin
            state_next.rd_state = BUS_RESP;
            state_next.rresp = RESP_OKAY;
            state_next.rdata = '0;
            case (s_axi_araddr)
                ENABLE_A_OFFSET: begin
                    state_next.rdata[7:0] =
                        state_reg.periph_irq_enable_a;
                end
                ENABLE_B_OFFSET: begin
                    state_next.rdata[7:0] =
                        state_reg.periph_irq_enable_b;
                end
                REQUEST_A_OFFSET: begin
                    state_next.rdata[7:0] = periph_irq_request_a;
                end
                CONTROL_OFFSET: begin
                    state_next.rdata[GROUP_BIT] =
                        state_reg.peripheral_group_enable;
                end
                default: begin
                    state_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (state_reg.rd_state == BUS_RESP && s_axi_rready) begin
            state_next.rd_state = BUS_IDLE;
        end
        state_next.periph_irq = state_reg.peripheral_group_enable
            && (|(periph_irq_request_a & state_reg.periph_irq_enable_a)
            || |(pend_b & state_reg.periph_irq_enable_b));
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '{
                wr_state: BUS_IDLE,
                rd_state: BUS_IDLE,
                aw_seen: 1'b0,
                w_seen: 1'b0,
                aw_addr: 4'h0,
                w_data: 32'h0,
                w_strb: 4'h0,
                bresp: RESP_OKAY,
                rdata: 32'h0,
                rresp: RESP_OKAY,
                periph_irq_enable_a: REG8_RESET,
                periph_irq_enable_b: REG8_RESET,
                request_a_sw: REG8_RESET,
                peripheral_group_enable: 1'b0,
                periph_irq: 1'b0
            };
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = !state_reg.aw_seen && clk_en;
    assign s_axi_wready = !state_reg.w_seen && clk_en;
    assign s_axi_bvalid = state_reg.wr_state == BUS_RESP;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.rd_state == BUS_IDLE && clk_en;
    assign s_axi_rvalid = state_reg.rd_state == BUS_RESP;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign periph_irq = state_reg.periph_irq;

endmodule

// ### rtl/pirq_pkg.sv
// package: register map, field positions and carriers for the irq block
package pirq_pkg;
    localparam logic [3:0] ENABLE_A_OFFSET = 4'h0;
    localparam logic [3:0] ENABLE_B_OFFSET = 4'h4;
    localparam logic [3:0] REQUEST_A_OFFSET = 4'h8;
    localparam logic [3:0] CONTROL_OFFSET = 4'hc;
    localparam logic [3:0] STATUS_OFFSET = 4'h0;
    localparam logic [7:0] ENABLE_A_MASK = 8'h7f;
    localparam logic [7:0] ENABLE_B_MASK = 8'hfd;
    localparam logic [7:0] REQUEST_A_SW_MASK = 8'h4f;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam int ADC_BIT = 6;
    localparam int RX_BIT = 5;
    localparam int TX_BIT = 4;
    localparam int SYNC_BIT = 3;
    localparam int CAPCMP_A_BIT = 2;
    localparam int PERIOD_BIT = 1;
    localparam int OVF_BIT = 0;
    localparam int GROUP_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_t;

    // peripheral event strobes for the first flag register
    typedef struct packed {
        logic adc_done;
        logic sync_done;
        logic sync_i2c_seq_done;
        logic sync_idle_start;
        logic capcmp_a_event;
        logic period_match;
        logic wide_timer_ovf;
    } events_a_t;

    typedef struct packed {
        bus_state_t wr_state;
        bus_state_t rd_state;
        logic aw_seen;
        logic w_seen;
        logic [3:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] periph_irq_enable_a;
        logic [7:0] periph_irq_enable_b;
        logic [7:0] request_a_sw;
        logic peripheral_group_enable;
        logic periph_irq;
    } state_t;
endpackage
